/* File: core/llcpd_map.svh */
// Offsets-free constant map: timing counts and field defaults for the line-locked clock core
`ifndef LLCPD_MAP_SVH
`define LLCPD_MAP_SVH

// Clock period of clk_sys_i in ns
`define LLCPD_CLK_PERIOD_NS       10
// Least feedback pulse width in ns
`define LLCPD_FB_MIN_WIDTH_NS     500
// Least feedback pulse width in cycles, rounded up
`define LLCPD_FB_MIN_WIDTH_CYC    ((`LLCPD_FB_MIN_WIDTH_NS + `LLCPD_CLK_PERIOD_NS - 1) / `LLCPD_CLK_PERIOD_NS)
// Least feedback width in output clock cycles
`define LLCPD_FB_MIN_OUT_CYC      16
// Pump current settings in microamperes
`define LLCPD_PUMP_LOW_UA         40
`define LLCPD_PUMP_HIGH_UA        80
// Nominal line rate in Hz
`define LLCPD_LINE_RATE_HZ        15625
// Default divider count and its width
`define LLCPD_DIV_COUNT_DEF       16'h0400
`define LLCPD_DIV_W               16

`endif

/* File: core/llcpd_pkg.sv */
// Types used by the device end and the bench of the line-locked clock core
package llcpd_pkg;
    typedef enum logic {
        LLCPD_GAIN_HIGH,
        LLCPD_GAIN_LOW
    } llcpd_gain_t;

    typedef enum logic [1:0] {
        LLCPD_PUMP_IDLE,
        LLCPD_PUMP_SOURCE,
        LLCPD_PUMP_SINK
    } llcpd_pump_t;
endpackage

/* File: core/llcpd_if.sv */
// Link between the clock core and the external feedback divider
`timescale 1ns/10ps
`default_nettype none
interface llcpd_if;
    logic feedback_pulse_in;
    logic line_reference_in;
    logic out_clk;
    logic out_clk_en;

    modport core (
        input  feedback_pulse_in,
        input  line_reference_in,
        output out_clk,
        output out_clk_en
    );
    modport divider (
        output feedback_pulse_in,
        input  out_clk,
        input  out_clk_en
    );
endinterface
`default_nettype wire

/* File: core/llcpd_divider.sv */
// Far end: programmable feedback divider that closes the loop
`timescale 1ns/10ps
`default_nettype none
`include "llcpd_map.svh"
module llcpd_divider #(
    parameter int DIV_W   = `LLCPD_DIV_W,
    parameter int LOW_CYC = `LLCPD_FB_MIN_OUT_CYC
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    // Control
    input  wire logic [DIV_W-1:0] div_count_i,
    input  wire logic             div_run_i,
    // Link
    llcpd_if.divider              lnk,
    // Status
    output logic [DIV_W-1:0]      div_phase_o
);
    if (DIV_W < 6 || LOW_CYC < 1) begin : g_bad_param
        $error("llcpd_divider: bad parameters");
    end

    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic             fb_ff;
    logic             nxt_fb;

    // One count per output clock cycle; the falling edge at wrap is the feedback event
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_fb  = fb_ff;
        if (!div_run_i) begin
            nxt_cnt = '0;
            nxt_fb  = 1'b1;
        end else if (lnk.out_clk_en) begin
            if (cnt_ff >= div_count_i - DIV_W'(1)) begin
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + DIV_W'(1);
            end
            // Low for the first LOW_CYC output cycles sets the pulse width
            nxt_fb = (nxt_cnt >= DIV_W'(LOW_CYC));
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
            fb_ff  <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            fb_ff  <= nxt_fb;
        end
    end

    assign lnk.feedback_pulse_in = fb_ff;
    assign div_phase_o           = cnt_ff;
endmodule
`default_nettype wire

/* File: core/llcpd_core.sv */
// Device end: type IV phase-frequency comparator and bypassable divide-by-two
`timescale 1ns/10ps
`default_nettype none
`include "llcpd_map.svh"
module llcpd_core (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    // Controls
    input  wire logic                 pump_gain_select_i,
    input  wire logic                 halve_en_i,
    input  wire logic                 osc_en_i,
    // Link
    llcpd_if.core                     lnk,
    // Pump requests
    output logic                      pump_up_o,
    output logic                      pump_down_o,
    output logic [6:0]                pump_ua_o,
    output llcpd_pkg::llcpd_pump_t    pump_state_o,
    // Output clock
    output logic                      clk_out_o
);
    // Pin synchronisers: three flops, change taken when second and third agree
    logic [2:0] ref_sync_ff;
    logic [2:0] fb_sync_ff;
    logic [2:0] half_sync_ff;
    logic [2:0] nxt_ref_sync;
    logic [2:0] nxt_fb_sync;
    logic [2:0] nxt_half_sync;
    logic       ref_lvl_ff;
    logic       fb_lvl_ff;
    logic       half_lvl_ff;
    logic       nxt_ref_lvl;
    logic       nxt_fb_lvl;
    logic       nxt_half_lvl;
    logic       ref_rise;
    logic       fb_fall;

    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    always_comb begin
        nxt_ref_sync  = {ref_sync_ff[1:0], lnk.line_reference_in};
        nxt_fb_sync   = {fb_sync_ff[1:0], lnk.feedback_pulse_in};
        nxt_half_sync = {half_sync_ff[1:0], halve_en_i};
        nxt_ref_lvl   = settle(ref_sync_ff, ref_lvl_ff);
        nxt_fb_lvl    = settle(fb_sync_ff, fb_lvl_ff);
        nxt_half_lvl  = settle(half_sync_ff, half_lvl_ff);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_sync_ff  <= 3'h0;
            fb_sync_ff   <= 3'h7;
            half_sync_ff <= 3'h0;
            ref_lvl_ff   <= 1'b0;
            fb_lvl_ff    <= 1'b1;
            half_lvl_ff  <= 1'b0;
        end else begin
            ref_sync_ff  <= nxt_ref_sync;
            fb_sync_ff   <= nxt_fb_sync;
            half_sync_ff <= nxt_half_sync;
            ref_lvl_ff   <= nxt_ref_lvl;
            fb_lvl_ff    <= nxt_fb_lvl;
            half_lvl_ff  <= nxt_half_lvl;
        end
    end

    // Only edges count, so input duty cycle plays no part
    assign ref_rise = nxt_ref_lvl & ~ref_lvl_ff;
    assign fb_fall  = ~nxt_fb_lvl & fb_lvl_ff;

    // Type IV detector: three states, no tolerance of missing edges
    llcpd_pkg::llcpd_pump_t st_ff;
    llcpd_pkg::llcpd_pump_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            llcpd_pkg::LLCPD_PUMP_IDLE: begin
                // Simultaneous edges mean in phase: stay idle
                if (ref_rise && !fb_fall) begin
                    nxt_st = llcpd_pkg::LLCPD_PUMP_SOURCE;
                end else if (fb_fall && !ref_rise) begin
                    nxt_st = llcpd_pkg::LLCPD_PUMP_SINK;
                end
            end
            llcpd_pkg::LLCPD_PUMP_SOURCE: begin
                if (fb_fall) begin
                    nxt_st = llcpd_pkg::LLCPD_PUMP_IDLE;
                end
            end
            llcpd_pkg::LLCPD_PUMP_SINK: begin
                if (ref_rise) begin
                    nxt_st = llcpd_pkg::LLCPD_PUMP_IDLE;
                end
            end
            default: begin
                nxt_st = llcpd_pkg::LLCPD_PUMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= llcpd_pkg::LLCPD_PUMP_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // One-hot decode of a single state keeps up and down exclusive
    assign pump_up_o    = (st_ff == llcpd_pkg::LLCPD_PUMP_SOURCE);
    assign pump_down_o  = (st_ff == llcpd_pkg::LLCPD_PUMP_SINK);
    assign pump_state_o = st_ff;

    // Gain select high means the low current
    logic [6:0] ua_ff;
    logic [6:0] nxt_ua;

    always_comb begin
        if (pump_gain_select_i) begin
            nxt_ua = 7'(`LLCPD_PUMP_LOW_UA);
        end else begin
            nxt_ua = 7'(`LLCPD_PUMP_HIGH_UA);
        end
        if (st_ff == llcpd_pkg::LLCPD_PUMP_IDLE) begin
            nxt_ua = 7'h00;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ua_ff <= 7'h00;
        end else begin
            ua_ff <= nxt_ua;
        end
    end

    assign pump_ua_o = ua_ff;

    // Oscillator stand-in is clk_sys_i gated by osc_en_i; output runs as an enable pulse
    logic half_ff;
    logic nxt_half;
    logic clk_ff;
    logic nxt_clk;
    logic en_ff;
    logic nxt_en;

    always_comb begin
        nxt_half = half_ff;
        nxt_clk  = clk_ff;
        nxt_en   = 1'b0;
        if (osc_en_i) begin
            if (half_lvl_ff) begin
                // Level moves on every second oscillator cycle: exact 50% duty
                nxt_half = ~half_ff;
                if (half_ff) begin
                    nxt_clk = ~clk_ff;
                    nxt_en  = 1'b1;
                end
            end else begin
                // Bypass: every oscillator cycle is an output cycle
                nxt_half = 1'b0;
                nxt_clk  = ~clk_ff;
                nxt_en   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_ff <= 1'b0;
            clk_ff  <= 1'b0;
            en_ff   <= 1'b0;
        end else begin
            half_ff <= nxt_half;
            clk_ff  <= nxt_clk;
            en_ff   <= nxt_en;
        end
    end

    assign clk_out_o      = clk_ff;
    assign lnk.out_clk    = clk_ff;
    assign lnk.out_clk_en = en_ff;
endmodule
`default_nettype wire

/* File: testbench/llcpd_monitor.sv */
// Checker on the link and pump ports of the line-locked clock core
`timescale 1ns/10ps
`default_nettype none
module llcpd_monitor (
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_b_i,
    // Link
    input wire logic       feedback_pulse_in,
    input wire logic       line_reference_in,
    input wire logic       out_clk,
    input wire logic       out_clk_en,
    // Controls
    input wire logic       pump_gain_select_i,
    input wire logic       halve_en_i,
    input wire logic       osc_en_i,
    // Pump requests
    input wire logic       pump_up_o,
    input wire logic       pump_down_o,
    input wire logic [6:0] pump_ua_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    property p_excl;
        !(pump_up_o && pump_down_o);
    endproperty
    a_excl: assert property (p_excl) else $error("up and down together");
    property p_ua;
        (pump_up_o || pump_down_o) |=> pump_ua_o == ($past(pump_gain_select_i) ? 7'h28 : 7'h50);
    endproperty
    a_ua: assert property (p_ua) else $error("pump current wrong");
    property p_idle_ua;
        !pump_up_o && !pump_down_o |=> pump_ua_o == 7'h00;
    endproperty
    a_idle_ua: assert property (p_idle_ua) else $error("idle current not zero");
    // Sync delay puts the edge between 5 and 4 samples back: one-cycle margin on the recent side only
    property p_up_rise;
        $rose(pump_up_o) |-> $past(line_reference_in, 3) && !$past(line_reference_in, 5);
    endproperty
    a_up_rise: assert property (p_up_rise) else $error("up without ref rise");
    property p_dn_rise;
        $rose(pump_down_o) |-> !$past(feedback_pulse_in, 3) && $past(feedback_pulse_in, 5);
    endproperty
    a_dn_rise: assert property (p_dn_rise) else $error("down without fb fall");
    property p_up_fall;
        $fell(pump_up_o) |-> !$past(feedback_pulse_in, 3) && $past(feedback_pulse_in, 5);
    endproperty
    a_up_fall: assert property (p_up_fall) else $error("up cleared early");
    property p_dn_fall;
        $fell(pump_down_o) |-> $past(line_reference_in, 3) && !$past(line_reference_in, 5);
    endproperty
    a_dn_fall: assert property (p_dn_fall) else $error("down cleared early");
    property p_halve;
        out_clk_en && halve_en_i && $past(halve_en_i, 5) && $past(rst_b_i, 3) |=> !out_clk_en;
    endproperty
    a_halve: assert property (p_halve) else $error("halving enable too often");
    property p_bypass;
        osc_en_i && $past(osc_en_i) && !halve_en_i && !$past(halve_en_i, 5) && $past(rst_b_i, 3)
            |=> out_clk_en && (out_clk != $past(out_clk));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass clock not toggling");
    property p_off;
        !osc_en_i && !$past(osc_en_i) |-> !out_clk_en;
    endproperty
    a_off: assert property (p_off) else $error("enable while stopped");
endmodule
`default_nettype wire

/* File: testbench/llcpd_tb.sv */
// Self-checking bench for the comparator core facing the feedback divider
`timescale 1ns/10ps
`default_nettype none
module llcpd_tb;
    logic                  clk_sys_i = 1'b0;
    logic                  rst_b_i   = 1'b0;
    logic                  gain      = 1'b1;
    logic                  halve     = 1'b0;
    logic                  osc       = 1'b1;
    logic                  run       = 1'b0;
    logic                  up;
    logic                  down;
    logic [6:0]            ua;
    llcpd_pkg::llcpd_pump_t st;
    int                    miscompares = 0;
    int                    compares    = 0;
    int                    n;
    int                    m;
    int                    k;
    logic                  prev;

    always #5 clk_sys_i = ~clk_sys_i;

    llcpd_if llcpd_if_i ();
    llcpd_core llcpd_core_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pump_gain_select_i(gain), .halve_en_i(halve), .osc_en_i(osc), .lnk(llcpd_if_i.core),
        .pump_up_o(up), .pump_down_o(down), .pump_ua_o(ua), .pump_state_o(st), .clk_out_o());
    llcpd_divider llcpd_divider_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .div_count_i(16'h0400), .div_run_i(run), .lnk(llcpd_if_i.divider), .div_phase_o());
    llcpd_monitor llcpd_monitor_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .feedback_pulse_in(llcpd_if_i.feedback_pulse_in),
        .line_reference_in(llcpd_if_i.line_reference_in),
        .out_clk(llcpd_if_i.out_clk), .out_clk_en(llcpd_if_i.out_clk_en),
        .pump_gain_select_i(gain), .halve_en_i(halve), .osc_en_i(osc),
        .pump_up_o(up), .pump_down_o(down), .pump_ua_o(ua));

    task summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bit 0 raises the reference, bit 1 starts the divider so feedback falls
    task step(input logic [1:0] kind, input int hi, input logic [10:0] exp);
        n = 0;
        @(posedge clk_sys_i);
        run <= kind[1];
        // Reference one edge later: the divider's register delay then lines both edges up
        @(posedge clk_sys_i);
        llcpd_if_i.line_reference_in <= kind[0];
        repeat (hi) begin
            @(posedge clk_sys_i);
            n += int'(up | down);
        end
        llcpd_if_i.line_reference_in <= 1'b0;
        run <= 1'b0;
        repeat (8) begin
            @(posedge clk_sys_i);
            n += int'(up | down);
        end
        chk({up, down, ua, st}, exp);
    endtask

    // Samples at the falling edge so the registered outputs have settled
    task clk_win(input int en_exp, input int hi_exp, input int tg_exp);
        n = 0;
        m = 0;
        k = 0;
        @(negedge clk_sys_i);
        prev = llcpd_if_i.out_clk;
        repeat (20) begin
            @(negedge clk_sys_i);
            n += int'(llcpd_if_i.out_clk_en === 1'b1);
            m += int'(llcpd_if_i.out_clk === 1'b1);
            k += int'(llcpd_if_i.out_clk !== prev);
            prev = llcpd_if_i.out_clk;
        end
        chk(11'(n), 11'(en_exp));
        if (hi_exp >= 0) chk(11'(m), 11'(hi_exp));
        chk(11'(k), 11'(tg_exp));
    endtask

    initial begin
        llcpd_if_i.line_reference_in <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        step(2'b01, 2, {1'b1, 1'b0, 7'h28, llcpd_pkg::LLCPD_PUMP_SOURCE});
        step(2'b01, 30, {1'b1, 1'b0, 7'h28, llcpd_pkg::LLCPD_PUMP_SOURCE});
        step(2'b10, 4, {1'b0, 1'b0, 7'h00, llcpd_pkg::LLCPD_PUMP_IDLE});
        gain <= 1'b0;
        step(2'b10, 3, {1'b0, 1'b1, 7'h50, llcpd_pkg::LLCPD_PUMP_SINK});
        step(2'b10, 20, {1'b0, 1'b1, 7'h50, llcpd_pkg::LLCPD_PUMP_SINK});
        step(2'b01, 5, {1'b0, 1'b0, 7'h00, llcpd_pkg::LLCPD_PUMP_IDLE});
        step(2'b11, 4, {1'b0, 1'b0, 7'h00, llcpd_pkg::LLCPD_PUMP_IDLE});
        chk(11'(n), 11'h000);
        clk_win(20, 10, 20);
        @(posedge clk_sys_i);
        halve <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        clk_win(10, 10, 10);
        @(posedge clk_sys_i);
        osc <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        clk_win(0, -1, 0);
        summarize();
    end
endmodule
`default_nettype wire
